// ---- rtl/pixel_signature_diagnostics.sv ----
// Pixel signature diagnostics: pixel mask, 24-bit signature register and comparator sense.
`default_nettype none
module pixel_signature_diagnostics
    import pixsig_pkg::*;
#(
    parameter int PIXEL_WIDTH = 32 // Width of the incoming pixel port.
) (
    input wire logic clk_i, // Pixel clock.
    input wire logic rst_i, // Synchronous active-high reset.
    input wire logic [31:0] wb_adr_i, // Wishbone address.
    input wire logic [31:0] wb_dat_i, // Wishbone write data.
    output logic [31:0] wb_dat_o, // Wishbone read data.
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
    input wire logic wb_we_i, // Wishbone write enable.
    input wire logic wb_cyc_i, // Wishbone cycle.
    input wire logic wb_stb_i, // Wishbone strobe.
    output logic wb_ack_o, // Wishbone acknowledge.
    input wire video_in_s video_i, // Pixel, blanking and parity pins.
    input wire logic [2:0] comparator_i, // Raw converter comparator results.
    output logic [23:0] converter_data_o, // Masked data toward the converters.
    output logic sense_n_o, // Active-low comparator output pin value.
    output logic sense_oe_o, // High while the sense pin is driven.
    output logic irq_o // Level interrupt.
);
    // ************************************************************
    // Elaboration checks.
    // ************************************************************
    if (PIXEL_WIDTH != 32) begin : g_bad_width
        $error("PIXEL_WIDTH must be 32");
    end

    // ************************************************************
    // Input synchronisers.
    // ************************************************************
    // Pins come from the controller's domain, so two stages precede any logic.
    video_in_s vid_meta; // First stage, read only by the second.
    video_in_s vid_sync; // Second stage, usable.
    logic [2:0] cmp_meta; // First comparator stage.
    logic [2:0] cmp_sync; // Second comparator stage.
    // Both stages clear on reset so blanking reads active.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vid_meta <= '0;
            vid_sync <= '0;
            cmp_meta <= 3'h0;
            cmp_sync <= 3'h0;
        end else begin
            vid_meta <= video_i;
            vid_sync <= vid_meta;
            cmp_meta <= comparator_i;
            cmp_sync <= cmp_meta;
        end
    end

    // ************************************************************
    // Software registers.
    // ************************************************************
    logic [7:0] pixel_mask; // One bit per nibble.
    logic signature_arm_ctrl; // Arm control.
    logic comparator_out_tristate; // Sense pin disable.
    logic sense_latched_sel; // Latched or unlatched for the pin.
    logic interlace_mode; // Interlace mode.
    logic parity_pin_select; // Shared pin used as field parity.
    logic [IRQ_WIDTH-1:0] irq_mask; // Interrupt enables.
    logic bus_req; // Request present.
    logic wr_stb; // One-cycle write strobe.
    assign bus_req = wb_cyc_i && wb_stb_i;
    assign wr_stb = bus_req && wb_we_i && !wb_ack_o && wb_sel_i[0];
    // Only lane 0 carries data; other lanes are ignored.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pixel_mask <= RST_PIXEL_MASK;
            signature_arm_ctrl <= RST_CTRL[0];
            comparator_out_tristate <= RST_CTRL[0];
            sense_latched_sel <= RST_CTRL[0];
            interlace_mode <= RST_CTRL[0];
            parity_pin_select <= RST_CTRL[0];
            irq_mask <= RST_CTRL[IRQ_WIDTH-1:0];
        end else if (wr_stb) begin
            case (wb_adr_i[7:0])
                OFS_PIXEL_MASK: begin
                    pixel_mask <= wb_dat_i[7:0];
                end
                OFS_MISC_CTRL1: begin
                    signature_arm_ctrl <= wb_dat_i[CTRL1_ARM_BIT];
                    comparator_out_tristate <= wb_dat_i[CTRL1_TRI_BIT];
                    sense_latched_sel <= wb_dat_i[CTRL1_SEL_BIT];
                end
                OFS_MISC_CTRL2: begin
                    interlace_mode <= wb_dat_i[CTRL2_INTL_BIT];
                    parity_pin_select <= wb_dat_i[CTRL2_PSEL_BIT];
                end
                OFS_IRQ_MASK: begin
                    irq_mask <= wb_dat_i[IRQ_WIDTH-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // Pixel mask and data path.
    // ************************************************************
    logic [31:0] masked_pixel; // Pixel after nibble masking.
    for (genvar n = 0; n < 8; n++) begin : g_nibble
        assign masked_pixel[4*n+3:4*n] = pixel_mask[n] ? 4'h0 : vid_sync.pixel[4*n+3:4*n];
    end
    // Low 24 bits feed the converters; the top byte carries no colour here.
    logic [23:0] conv_data; // Data presented to the converters.
    // Registered so that the converter data output comes from flip-flops.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_data <= 24'h000000;
        end else begin
            conv_data <= vid_sync.blank_n ? masked_pixel[23:0] : 24'h000000;
        end
    end
    assign converter_data_o = conv_data;

    // ************************************************************
    // Blanking edges and field parity.
    // ************************************************************
    logic blank_n_q; // Previous blanking level.
    logic vblank_det; // Falling edge of blank_n: blanking detected.
    logic blank_rise; // Rising edge of blank_n: display starts.
    logic odd_field; // Effective odd field indication.
    logic intl_active; // Interlace honoured only with parity pin use.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blank_n_q <= 1'b0;
        end else begin
            blank_n_q <= vid_sync.blank_n;
        end
    end
    assign vblank_det = blank_n_q && !vid_sync.blank_n;
    assign blank_rise = !blank_n_q && vid_sync.blank_n;
    assign intl_active = interlace_mode && parity_pin_select;
    assign odd_field = vid_sync.parity;

    // ************************************************************
    // Signature sequencer.
    // ************************************************************
    // Blanking detection is simplified to each blank_n fall; a caller that blanks
    // horizontally should hold blank_n high across lines if only vertical edges matter.
    sig_state_e sig_state; // Sequencer state.
    logic arm_q; // Previous arm bit.
    logic arm_rise; // Zero-to-one change of the arm bit.
    logic even_seen; // Even field reached in interlace mode.
    logic signature_complete_flag; // Completion flag.
    logic sig_start; // One-cycle start event.
    logic sig_stop; // One-cycle stop event.
    assign arm_rise = signature_arm_ctrl && !arm_q;
    assign sig_start = (sig_state == SIG_ARMED) && blank_rise && (!intl_active || odd_field);
    assign sig_stop = (sig_state == SIG_RUN) && vblank_det && (!intl_active || even_seen);
    // The sequencer leaves idle only on a fresh rise of the arm bit, so completion sticks.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            arm_q <= 1'b0;
            sig_state <= SIG_IDLE;
            even_seen <= 1'b0;
            signature_complete_flag <= 1'b0;
        end else begin
            arm_q <= signature_arm_ctrl;
            case (sig_state)
                SIG_IDLE: begin
                    if (arm_rise) begin
                        sig_state <= SIG_WAIT_ARM;
                    end
                end
                SIG_WAIT_ARM: begin
                    if (vblank_det) begin
                        sig_state <= SIG_ARMED;
                    end
                end
                SIG_ARMED: begin
                    if (sig_start) begin
                        sig_state <= SIG_RUN;
                        even_seen <= 1'b0;
                        signature_complete_flag <= 1'b0;
                    end
                end
                SIG_RUN: begin
                    if (sig_stop) begin
                        sig_state <= SIG_IDLE;
                        signature_complete_flag <= 1'b1;
                    end else if (blank_rise && !odd_field) begin
                        even_seen <= 1'b1;
                    end
                end
                default: begin
                    sig_state <= SIG_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Signature register.
    // ************************************************************
    logic [23:0] signature; // Blue, green, red bytes from high to low.
    logic [23:0] next_signature; // Next signature value.
    logic accumulating; // Shift enable during displayed pixels.
    assign accumulating = (sig_state == SIG_RUN) && blank_n_q && !sig_stop;
    always_comb begin
        next_signature = {signature[22:0], 1'b0} ^ (signature[23] ? SIG_POLY : 24'h000000) ^ conv_data;
    end
    // Every displayed converter value but the last one before the stop, border and cursor pixels alike, is folded in.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            signature <= 24'h000000;
        end else if (sig_start) begin
            signature <= 24'h000000;
        end else if (accumulating) begin
            signature <= next_signature;
        end
    end

    // ************************************************************
    // Comparator sense.
    // ************************************************************
    logic [2:0] cmp_latched; // Copy captured while pixels are sampled.
    logic sense_and; // AND of the selected bits.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_latched <= 3'h0;
        end else if (vid_sync.blank_n) begin
            cmp_latched <= cmp_sync;
        end
    end
    assign sense_and = sense_latched_sel ? &cmp_latched : &cmp_sync;
    assign sense_n_o = !sense_and;
    assign sense_oe_o = !comparator_out_tristate;

    // ************************************************************
    // Interrupts.
    // ************************************************************
    logic [IRQ_WIDTH-1:0] irq_status; // Sticky event bits.
    logic [IRQ_WIDTH-1:0] irq_set; // This cycle's events.
    logic [IRQ_WIDTH-1:0] irq_clr; // Write-one-to-clear bits.
    assign irq_set = {sig_start, sig_stop};
    assign irq_clr = (wr_stb && wb_adr_i[7:0] == OFS_IRQ_STATUS) ? wb_dat_i[IRQ_WIDTH-1:0] : '0;
    // Set wins over clear so an event in the clearing cycle survives.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
        end
    end
    assign irq_o = |(irq_status & irq_mask);

    // ************************************************************
    // Bus read path.
    // ************************************************************
    logic [31:0] rd_data; // Combinational read mux.
    always_comb begin
        rd_data = 32'h00000000;
        case (wb_adr_i[7:0])
            OFS_PIXEL_MASK: rd_data[7:0] = pixel_mask;
            OFS_MISC_CTRL1: rd_data[2:0] = {sense_latched_sel, comparator_out_tristate, signature_arm_ctrl};
            OFS_MISC_CTRL2: rd_data[1:0] = {parity_pin_select, interlace_mode};
            OFS_SIG_STATUS: rd_data[1:0] = {sig_state != SIG_IDLE, signature_complete_flag};
            OFS_SIG_RED: rd_data[7:0] = signature[7:0];
            OFS_SIG_GREEN: rd_data[7:0] = signature[15:8];
            OFS_SIG_BLUE: rd_data[7:0] = signature[23:16];
            OFS_SENSE: rd_data[5:0] = {cmp_latched, cmp_sync};
            OFS_IRQ_STATUS: rd_data[IRQ_WIDTH-1:0] = irq_status;
            OFS_IRQ_MASK: rd_data[IRQ_WIDTH-1:0] = irq_mask;
            default: rd_data = 32'h00000000;
        endcase
    end
    // One wait state: ack one cycle after the request, dropped the next.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req && !wb_ack_o;
            wb_dat_o <= rd_data;
        end
    end

    // ************************************************************
    // Checks.
    // ************************************************************
    chk_done_sets: assert property (@(posedge clk_i) disable iff (rst_i)
        sig_stop |=> signature_complete_flag && sig_state == SIG_IDLE)
        else $error("completion flag not set after stop");
    chk_frozen_sig: assert property (@(posedge clk_i) disable iff (rst_i)
        (sig_state == SIG_IDLE) && $past(sig_state == SIG_IDLE) |-> $stable(signature))
        else $error("signature changed while idle");
    chk_start_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        sig_start |=> signature == 24'h000000 && !signature_complete_flag)
        else $error("start did not clear signature");
    chk_arm_vblank: assert property (@(posedge clk_i) disable iff (rst_i)
        (sig_state == SIG_WAIT_ARM) && vblank_det |=> sig_state == SIG_ARMED)
        else $error("vblank did not arm");
    chk_odd_start: assert property (@(posedge clk_i) disable iff (rst_i)
        sig_start && intl_active |-> odd_field)
        else $error("interlace start on even field");
    chk_mask_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        pixel_mask[0] && vid_sync.blank_n |=> conv_data[3:0] == 4'h0)
        else $error("masked nibble not zero");
    chk_sense_and: assert property (@(posedge clk_i) disable iff (rst_i)
        !sense_latched_sel && (cmp_sync == 3'h7) |-> !sense_n_o)
        else $error("sense pin wrong");
    chk_tristate_pin: assert property (@(posedge clk_i) disable iff (rst_i)
        comparator_out_tristate |-> !sense_oe_o)
        else $error("sense pin driven while disabled");
endmodule : pixel_signature_diagnostics
`default_nettype wire

// ---- inc/pixsig_pkg.sv ----
// Package for the pixel signature diagnostics block: offsets, fields and reset values.
`default_nettype none
package pixsig_pkg;
    // ************************************************************
    // Register offsets (byte addresses on the Wishbone slave).
    // ************************************************************
    localparam logic [7:0] OFS_PIXEL_MASK = 8'h00; // Nibble mask for the pixel input.
    localparam logic [7:0] OFS_MISC_CTRL1 = 8'h04; // Arm control, tristate and sense select.
    localparam logic [7:0] OFS_MISC_CTRL2 = 8'h08; // Interlace mode and parity pin select.
    localparam logic [7:0] OFS_SIG_STATUS = 8'h0c; // Completion flag and busy state.
    localparam logic [7:0] OFS_SIG_RED = 8'h10; // Red signature byte.
    localparam logic [7:0] OFS_SIG_GREEN = 8'h14; // Green signature byte.
    localparam logic [7:0] OFS_SIG_BLUE = 8'h18; // Blue signature byte.
    localparam logic [7:0] OFS_SENSE = 8'h1c; // Comparator latched and unlatched bits.
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h20; // Sticky event bits, write one to clear.
    localparam logic [7:0] OFS_IRQ_MASK = 8'h24; // Interrupt enables.
    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int CTRL1_ARM_BIT = 0; // Signature arm control bit.
    localparam int CTRL1_TRI_BIT = 1; // Comparator output tristate bit.
    localparam int CTRL1_SEL_BIT = 2; // One selects latched comparator bits.
    localparam int CTRL2_INTL_BIT = 0; // Interlace mode bit.
    localparam int CTRL2_PSEL_BIT = 1; // One selects parity use of the shared pin.
    localparam int IRQ_DONE_BIT = 0; // Signature completion event.
    localparam int IRQ_START_BIT = 1; // Signature start event.
    localparam int IRQ_WIDTH = 2; // Number of event bits.
    // ************************************************************
    // Reset values and the feedback polynomial.
    // ************************************************************
    localparam logic [7:0] RST_PIXEL_MASK = 8'h00; // No nibble masked after reset.
    localparam logic [7:0] RST_CTRL = 8'h00; // Control bits clear after reset.
    localparam logic [23:0] SIG_POLY = 24'he10000; // Taps 24,23,22,17 give a maximal sequence.
    // Sequencer states of the signature logic.
    typedef enum logic [1:0] {
        SIG_IDLE = 2'b00,
        SIG_WAIT_ARM = 2'b01,
        SIG_ARMED = 2'b10,
        SIG_RUN = 2'b11
    } sig_state_e;
    // Video inputs travelling together from the graphics controller.
    typedef struct packed {
        logic blank_n; // Active-low blanking.
        logic parity; // Shared border or odd field pin.
        logic [31:0] pixel; // Raw pixel data.
    } video_in_s;
endpackage : pixsig_pkg
`default_nettype wire

// ---- dv/video_source.sv ----
// Behavioural graphics controller that drives pixel data, blanking and field parity.
`default_nettype none
module video_source
    import pixsig_pkg::*;
(
    input wire logic clk_i, // Pixel clock.
    output video_in_s video_o // Pins toward the block.
);
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // Pixel pattern.
    // ************************************************************
    int seed = 2; // Fixed seed so that every run sees the same pixels.
    initial video_o = '{blank_n: 1'b0, parity: 1'b0, pixel: 32'h0};
    // Pixels change every cycle, also in blanking, so stale data is never mistaken for a match.
    always @(posedge clk_i) begin
        video_o.pixel <= $random(seed);
    end
    // Blanking period; parity only moves here, while the screen is dark.
    task automatic blank(input logic par, input int n);
        video_o.blank_n <= 1'b0;
        video_o.parity <= par;
        repeat (n) @(posedge clk_i);
    endtask
    // Displayed period; blanking stays high after it until the next blank call.
    task automatic show(input int n);
        video_o.blank_n <= 1'b1;
        repeat (n) @(posedge clk_i);
    endtask
endmodule // video_source
`default_nettype wire

// ---- dv/tb_pixel_signature_diagnostics.sv ----
// Self-checking bench for the pixel signature diagnostics block.
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((ex) !== (got)) begin bad_count++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module tb_pixel_signature_diagnostics
    import pixsig_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // Clock, reset, bus and pin signals.
    // ************************************************************
    logic clk_i = 1'b0; // Pixel clock at 20 MHz.
    logic rst_i = 1'b1; // Held for two cycles at the start.
    logic [31:0] adr = 32'h0, dat = 32'h0, rdat; // Bus request and answer.
    logic [3:0] sel = 4'h0; // Byte selects.
    logic we = 1'b0, cyc = 1'b0, stb = 1'b0, ack; // Bus qualifiers.
    video_in_s vid; // Pins from the partner.
    logic [2:0] cmp = 3'b000; // Comparator inputs.
    logic [23:0] conv; // Data toward the converters.
    logic sense_n, sense_oe, irq; // Pin outputs.
    logic [31:0] h0, h1, h2; // Pixel history matching the pipeline depth.
    logic [32:0] q[$]; // Expected read data; bit 32 asks only for a nonzero value.
    int bad_count = 0, n_checks = 0;
    int seed = 2; // Seed of the bench's own random draws.
    always #25 clk_i = ~clk_i;
    pixel_signature_diagnostics DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
        .video_i(vid), .comparator_i(cmp), .converter_data_o(conv), .sense_n_o(sense_n),
        .sense_oe_o(sense_oe), .irq_o(irq));
    video_source src (.clk_i(clk_i), .video_o(vid));
    // ************************************************************
    // Bus master and read monitor.
    // ************************************************************
    // One classic cycle; the request stands until ack is sampled high.
    // Upper byte lanes are random: only lane 0 carries data, so they must not matter.
    task automatic wb(input logic w, input logic [7:0] a, input logic [32:0] d);
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {24'h0, a}; dat <= d[31:0];
        sel <= 4'h1 | 4'($random(seed));
        if (!w) q.push_back(d);
        // Only the watchdog ends a wait that never sees ack.
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    // Takes the oldest note at each read answer and compares it.
    always @(posedge clk_i) begin
        logic [32:0] e;
        if (ack === 1'b1 && cyc && !we && q.size() > 0) begin
            e = q.pop_front();
            if (e[32]) `CHK("sig_nonzero", 1'b1, rdat !== 32'h0)
            else `CHK("read", e[31:0], rdat)
        end
        h2 <= h1; h1 <= h0; h0 <= vid.pixel;
    end
    // Expected converter data: each of mask bits 0 to 5 zeroes one nibble.
    function automatic logic [23:0] mexp(input logic [7:0] m, input logic [31:0] p);
        logic [23:0] r;
        r = p[23:0];
        for (int i = 0; i < 6; i++) if (m[i]) r[4*i +: 4] = 4'h0;
        return r;
    endfunction
    // Compares the converter stream over a run of displayed pixels.
    task automatic conv_chk(input logic [7:0] m);
        repeat (12) begin
            @(negedge clk_i);
            `CHK("conv", mexp(m, h2), conv)
        end
        // Back on a rising edge, so the next stimulus is driven there.
        @(posedge clk_i);
    endtask
    task automatic stat(input logic [31:0] sg, input logic [31:0] st);
        wb(0, OFS_SIG_RED, {1'b0, 24'h0, sg[7:0]});
        wb(0, OFS_SIG_GREEN, {1'b0, 24'h0, sg[15:8]});
        wb(0, OFS_SIG_BLUE, {1'b0, 24'h0, sg[23:16]});
        wb(0, OFS_SIG_STATUS, {1'b0, st});
    endtask
    // ************************************************************
    // Verdict and watchdog.
    // ************************************************************
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // The tests need well under ten thousand cycles; this cuts a hang short.
    initial begin
        #(20000 * 50);
        bad_count++;
        report_and_stop();
    end
    // ************************************************************
    // Main sequence.
    // ************************************************************
    initial begin
        logic [7:0] rst_ofs [5]; // Registers that read zero after reset, plus an unmapped one.
        rst_ofs = '{OFS_PIXEL_MASK, OFS_MISC_CTRL1, OFS_MISC_CTRL2, OFS_SIG_STATUS, 8'h30};
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rst_ofs[i])
            wb(0, rst_ofs[i], 33'h0);
        `CHK("sense_oe_rst", 1'b1, sense_oe)
        // Nibble masking of the displayed stream.
        wb(1, OFS_PIXEL_MASK, 33'h05);
        src.show(6);
        conv_chk(8'h05);
        // Comparator copies: latch while displayed, then change inside blanking.
        cmp <= 3'b101;
        src.show(8);
        src.blank(1'b0, 2);
        cmp <= 3'b111;
        src.blank(1'b0, 8);
        wb(0, OFS_SENSE, 33'h2f);
        `CHK("sense_unlatched", 1'b0, sense_n)
        wb(1, OFS_MISC_CTRL1, 33'h4);
        src.blank(1'b0, 2);
        `CHK("sense_latched", 1'b1, sense_n)
        wb(1, OFS_MISC_CTRL1, 33'h2);
        src.blank(1'b0, 2);
        `CHK("sense_tristate", 1'b0, sense_oe)
        // Fully masked frame: signature must be exactly zero; arm written in blanking.
        wb(1, OFS_PIXEL_MASK, 33'hff);
        wb(1, OFS_IRQ_MASK, 33'h1);
        wb(1, OFS_MISC_CTRL1, 33'h1);
        src.show(30);
        wb(0, OFS_IRQ_STATUS, 33'h0);
        src.blank(1'b0, 8);
        src.show(30);
        wb(0, OFS_IRQ_STATUS, 33'h2);
        src.blank(1'b0, 8);
        stat(32'h0, 32'h1);
        `CHK("irq_done", 1'b1, irq)
        // Completion holds while arm falls and unmasked frames pass.
        wb(1, OFS_MISC_CTRL1, 33'h0);
        wb(1, OFS_PIXEL_MASK, 33'h00);
        src.show(30);
        src.blank(1'b0, 8);
        stat(32'h0, 32'h1);
        wb(1, OFS_IRQ_STATUS, 33'h3);
        `CHK("irq_clear", 1'b0, irq)
        // Fresh rise of the arm bit repeats the sequence on live data.
        wb(1, OFS_MISC_CTRL1, 33'h1);
        src.show(20);
        src.blank(1'b0, 8);
        src.show(30);
        wb(0, OFS_SIG_STATUS, 33'h2);
        src.blank(1'b0, 8);
        wb(0, OFS_SIG_RED, {1'b1, 32'h0});
        wb(0, OFS_SIG_STATUS, 33'h1);
        // Interlace: start only on an odd field, stop after the following even field.
        wb(1, OFS_MISC_CTRL1, 33'h0);
        wb(1, OFS_PIXEL_MASK, 33'hff);
        wb(1, OFS_MISC_CTRL2, 33'h3);
        wb(1, OFS_IRQ_STATUS, 33'h3);
        wb(1, OFS_MISC_CTRL1, 33'h1);
        src.show(20);
        src.blank(1'b0, 8);
        src.show(20);
        wb(0, OFS_IRQ_STATUS, 33'h0);
        src.blank(1'b1, 8);
        src.show(20);
        wb(0, OFS_IRQ_STATUS, 33'h2);
        src.blank(1'b0, 8);
        wb(0, OFS_SIG_STATUS, 33'h2);
        src.show(20);
        src.blank(1'b0, 8);
        stat(32'h0, 32'h1);
        // Random comparator inputs in blanking: latched copy stays at the last displayed value.
        repeat (4) begin
            cmp <= 3'($random(seed));
            repeat (4) @(posedge clk_i);
            `CHK("sense_random", ~&cmp, sense_n)
            wb(0, OFS_SENSE, {1'b0, 26'h0, 3'b111, cmp});
        end
        report_and_stop();
    end
endmodule // tb_pixel_signature_diagnostics
`default_nettype wire
